// ### testbench/alarm_timing_regs_asserts.sv
`timescale 1ns/1ps

// watches the register port answers and the per-core delay selection
module alarm_timing_regs_chk (
    input wire clk,
    input wire rst,
    input wire [11:0] reg_addr,
    input wire reg_rd,
    input wire reg_ready,
    input wire [15:0] reg_rdata,
    input wire reg_rvalid,
    input wire dual_mode,
    input wire first_analog_input,
    input wire fg_cal_en,
    input wire alarm_summary,
    input wire core_a_delay_valid,
    input wire core_b_delay_valid
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // read answers and their timing, and quiet summary and ready right after reset
    a_read_answer: assert property (reg_rd && reg_ready |-> ##2 reg_rvalid)
        else $error("read not answered after two cycles");
    a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd && reg_ready, 2))
        else $error("read answer without a taken read");
    a_unmapped_zero: assert property (reg_rd && reg_ready && reg_addr == 12'h2C3
        |-> ##2 reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (reg_rd && reg_ready && reg_addr >= 12'h310
        |-> ##2 reg_rdata[15:8] == 8'h00)
        else $error("delay read upper byte not zero");
    a_reset_quiet: assert property ($fell(rst) |-> !alarm_summary && !reg_ready)
        else $error("summary or ready up right after reset");
    // one delay register applies per core and mode
    a_core_a_dual: assert property (reg_ready && dual_mode |=> core_a_delay_valid)
        else $error("core a dual delay not applied");
    a_core_b_dual: assert property (reg_ready && dual_mode
        |=> core_b_delay_valid == $past(fg_cal_en))
        else $error("core b dual delay validity wrong");
    a_core_a_single: assert property (reg_ready && !dual_mode
        |=> core_a_delay_valid == $past(first_analog_input && fg_cal_en))
        else $error("core a single delay validity wrong");
    a_core_b_single: assert property (reg_ready && !dual_mode
        |=> core_b_delay_valid == $past(first_analog_input && fg_cal_en))
        else $error("core b single delay validity wrong");

    // main scenarios reached
    c_read: cover property (reg_rvalid);
    c_summary: cover property (alarm_summary);
    c_single_b: cover property (!dual_mode && core_b_delay_valid);
endmodule // alarm_timing_regs_chk

bind alarm_timing_regs alarm_timing_regs_chk u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_ready(reg_ready), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .dual_mode(dual_mode), .first_analog_input(first_analog_input), .fg_cal_en(fg_cal_en),
    .alarm_summary(alarm_summary), .core_a_delay_valid(core_a_delay_valid),
    .core_b_delay_valid(core_b_delay_valid));

// ### testbench/alarm_timing_regs_tb.sv
`timescale 1ns/1ps
`include "alarm_timing_defs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("FAIL %s exp %h got %h", n, e, g); end end

module alarm_timing_regs_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] addr = 12'h000;
    logic [15:0] wdata = 16'h0000, lf = 16'h0000, la = 16'h0000, e_h;
    logic wr = 1'b0, rd = 1'b0, dual = 1'b1, first = 1'b0, fg = 1'b0;
    logic [5:0] ev = 6'h00;
    logic [7:0] fz [4];
    logic [7:0] tv [4];
    logic [11:0] at [4] = '{`ADDR_CORE_A_DUAL, `ADDR_CORE_B_DUAL, `ADDR_CORE_A_SINGLE_FIRST,
        `ADDR_CORE_B_SINGLE_FIRST};
    logic [15:0] exp_q [$];
    wire [15:0] rdata;
    wire rvalid, ready, summ, va, vb;
    wire [7:0] da, db;
    int fails = 0, compares = 0, cyc = 0, k = 0, j;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    alarm_timing_regs u_dut (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid), .reg_ready(ready),
        .lane_fifo_fault(lf | ({15'h0000, ev[5]} << k)), .lane_active(la),
        .lock_loss_event(ev[4]), .link_fault_event(ev[3]), .realign_event(ev[2]),
        .oscillator_phase_event(ev[1]), .divider_mismatch_event(ev[0]),
        .fuse_core_a_dual(fz[0]), .fuse_core_b_dual(fz[1]), .fuse_core_a_single_first(fz[2]),
        .fuse_core_b_single_first(fz[3]), .dual_mode(dual), .first_analog_input(first),
        .fg_cal_en(fg), .alarm_summary(summ), .core_a_delay(da), .core_b_delay(db),
        .core_a_delay_valid(va), .core_b_delay_valid(vb));

    // verdict and end of run
    task results;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one-cycle write strobe
    task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    // one-cycle read strobe, expectation noted for the monitor
    task automatic rd_reg(input logic [11:0] a, input logic [15:0] e);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        exp_q.push_back(e);
        @(negedge clk);
        rd = 1'b0;
    endtask

    // one-cycle pulse on a flag source, then let the summary settle
    task automatic pulse(input int i);
        @(negedge clk);
        ev[i] = 1'b1;
        @(negedge clk);
        ev = 6'h00;
        repeat (3) @(negedge clk);
    endtask

    // read answers against the oldest note, looked at mid-cycle, plus the hang limit
    always @(negedge clk)
    begin
        cyc <= cyc + 1;
        if (rvalid === 1'b1 && exp_q.size() > 0)
        begin
            e_h = exp_q.pop_front();
            `CHK("rdata", e_h, rdata)
        end
        else if (rvalid === 1'b1)
            `CHK("spare rvalid", 1'b0, rvalid)
        if (cyc > 3000)
        begin
            fails++;
            results();
        end
    end

    // main sequence
    initial
    begin
        void'($urandom(32'h811E));
        for (j = 0; j < 4; j++)
            fz[j] = $urandom;
        k = $urandom % 16;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (20) if (ready !== 1'b1) @(negedge clk);
        `CHK("ready", 1'b1, ready)
        rd_reg(`ADDR_FAULT_SUPPRESS, 16'h003F);
        rd_reg(`ADDR_LANE_FIFO_FAULTS, 16'hFFFF);
        rd_reg(`ADDR_SUMMARY_ALARM, 16'h0000);
        rd_reg(12'h2C3, 16'h0000);
        for (j = 0; j < 4; j++)
            rd_reg(at[j], {8'h00, fz[j]});
        // lane flags: write-one-to-clear, persisting and new faults
        wr_reg(`ADDR_LANE_FIFO_FAULTS, 16'h00FF);
        rd_reg(`ADDR_LANE_FIFO_FAULTS, 16'hFF00);
        wr_reg(`ADDR_LANE_FIFO_FAULTS, 16'h0000);
        rd_reg(`ADDR_LANE_FIFO_FAULTS, 16'hFF00);
        lf = 16'h0008;
        wr_reg(`ADDR_LANE_FIFO_FAULTS, 16'hFFFF);
        rd_reg(`ADDR_LANE_FIFO_FAULTS, 16'h0008);
        lf = 16'h0000;
        wr_reg(`ADDR_LANE_FIFO_FAULTS, 16'h0008);
        lf = 16'h0200;
        @(negedge clk);
        lf = 16'h0000;
        rd_reg(`ADDR_LANE_FIFO_FAULTS, 16'h0200);
        wr_reg(`ADDR_FAULT_FLAGS, 16'h0020);
        rd_reg(`ADDR_LANE_FIFO_FAULTS, 16'h0000);
        rd_reg(`ADDR_FAULT_FLAGS, 16'h001F);
        // each source alone unsuppressed, a suppressed one first
        la = 16'h0001 << k;
        wr_reg(`ADDR_FAULT_FLAGS, 16'h003F);
        for (j = 0; j < 6; j++)
        begin
            wr_reg(`ADDR_FAULT_SUPPRESS, 16'h003F ^ (16'h0001 << j));
            pulse((j + 1) % 6);
            `CHK("summary masked", 1'b0, summ)
            pulse(j);
            `CHK("summary", 1'b1, summ)
            rd_reg(`ADDR_SUMMARY_ALARM, 16'h0001);
            wr_reg(`ADDR_FAULT_FLAGS, 16'h003F);
            repeat (3) @(negedge clk);
            `CHK("summary clear", 1'b0, summ)
        end
        wr_reg(`ADDR_FAULT_SUPPRESS, 16'h001F);
        la = 16'h0000;
        pulse(5);
        `CHK("inactive lane", 1'b0, summ)
        // delay registers overwritten, then applied per mode
        for (j = 0; j < 4; j++)
        begin
            tv[j] = $urandom;
            wr_reg(at[j], {8'($urandom), tv[j]});
            rd_reg(at[j], {8'h00, tv[j]});
        end
        `CHK("a dual valid", 1'b1, va)
        `CHK("b dual off", 1'b0, vb)
        fg = 1'b1;
        repeat (3) @(negedge clk);
        `CHK("a dual", tv[0], da)
        `CHK("b dual", tv[1], db)
        `CHK("b dual valid", 1'b1, vb)
        dual = 1'b0;
        first = 1'b1;
        repeat (3) @(negedge clk);
        `CHK("a single", tv[2], da)
        `CHK("b single", tv[3], db)
        `CHK("a single valid", 1'b1, va)
        `CHK("b single valid", 1'b1, vb)
        first = 1'b0;
        repeat (2) @(negedge clk);
        `CHK("a other input", 1'b0, va)
        `CHK("b other input", 1'b0, vb)
        repeat (4) @(negedge clk);
        `CHK("queue", 0, exp_q.size())
        results();
    end
endmodule // alarm_timing_regs_tb

// ### verilog/alarm_timing_defs.vh
`ifndef ALARM_TIMING_DEFS_VH
`define ALARM_TIMING_DEFS_VH

// register offsets
`define ADDR_SUMMARY_ALARM 12'h2C0
`define ADDR_FAULT_FLAGS 12'h2C1
`define ADDR_FAULT_SUPPRESS 12'h2C2
`define ADDR_LANE_FIFO_FAULTS 12'h2C4
`define ADDR_CORE_A_DUAL 12'h310
`define ADDR_CORE_B_DUAL 12'h313
`define ADDR_CORE_A_SINGLE_FIRST 12'h314
`define ADDR_CORE_B_SINGLE_FIRST 12'h315

// field positions in the flag and suppress registers
`define BIT_DIVIDER 0
`define BIT_OSC_PHASE 1
`define BIT_REALIGN 2
`define BIT_LINK 3
`define BIT_LOCK 4
`define BIT_FIFO 5

// reset values
`define RST_FAULT_FLAGS 8'h3F
`define RST_FAULT_SUPPRESS 8'h3F
`define RST_LANE_FIFO_FAULTS 16'hFFFF

// timing-adjust memory slots
`define SLOT_A_DUAL 2'h0
`define SLOT_B_DUAL 2'h1
`define SLOT_A_SINGLE 2'h2
`define SLOT_B_SINGLE 2'h3
`define DELAY_SLOTS 4

`endif

// ### verilog/alarm_timing_regs.v
`timescale 1ns/1ps
`include "alarm_timing_defs.vh"

module alarm_timing_regs (
    input wire clk,
    input wire rst,
    input wire [11:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    output reg reg_rvalid,
    output reg reg_ready,
    input wire [15:0] lane_fifo_fault,
    input wire [15:0] lane_active,
    input wire lock_loss_event,
    input wire link_fault_event,
    input wire realign_event,
    input wire oscillator_phase_event,
    input wire divider_mismatch_event,
    input wire [7:0] fuse_core_a_dual,
    input wire [7:0] fuse_core_b_dual,
    input wire [7:0] fuse_core_a_single_first,
    input wire [7:0] fuse_core_b_single_first,
    input wire dual_mode,
    input wire first_analog_input,
    input wire fg_cal_en,
    output reg alarm_summary,
    output wire [7:0] core_a_delay,
    output wire [7:0] core_b_delay,
    output reg core_a_delay_valid,
    output reg core_b_delay_valid
);

    localparam [1:0] ST_LOAD = 2'b01;
    localparam [1:0] ST_RUN = 2'b10;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [1:0] load_slot;
    reg [7:0] fault_flag_register;
    reg [7:0] fault_suppress_register;
    reg [15:0] lane_fifo_fault_flags;
    reg rd_pend;
    reg rd_from_mem;
    reg [15:0] rd_local;
    reg [15:0] rd_hold;
    reg [1:0] a_slot;
    reg [1:0] b_slot;
    reg next_a_valid;
    reg next_b_valid;
    reg [7:0] fuse_word;
    reg mem_wr;
    reg [1:0] mem_slot;
    reg [7:0] mem_wdata;
    wire host_wr;
    wire wr_flags;
    wire wr_lanes;
    wire [5:0] event_set;
    wire [15:0] lane_set;
    wire [7:0] next_flags;
    wire [15:0] next_lanes;
    wire [7:0] mem_host_data;
    wire [2:0] addr_slot;

    // map a host address to a timing-adjust slot
    function [2:0] delay_slot;
        input [11:0] addr;
        begin
            case (addr)
                `ADDR_CORE_A_DUAL: delay_slot = {1'b1, `SLOT_A_DUAL};
                `ADDR_CORE_B_DUAL: delay_slot = {1'b1, `SLOT_B_DUAL};
                `ADDR_CORE_A_SINGLE_FIRST: delay_slot = {1'b1, `SLOT_A_SINGLE};
                `ADDR_CORE_B_SINGLE_FIRST: delay_slot = {1'b1, `SLOT_B_SINGLE};
                default: delay_slot = 3'h0;
            endcase
        end
    endfunction

    assign host_wr = reg_wr && (state == ST_RUN);
    assign wr_flags = host_wr && (reg_addr == `ADDR_FAULT_FLAGS);
    assign wr_lanes = host_wr && (reg_addr == `ADDR_LANE_FIFO_FAULTS);

    // decoded timing-adjust slot of the bus address; bit 2 marks a delay register
    assign addr_slot = delay_slot(reg_addr);

    // hardware set terms for the lane flags and the flag register
    assign lane_set = lane_fifo_fault;
    assign event_set[`BIT_FIFO] = |(lane_fifo_fault & lane_active);
    assign event_set[`BIT_LOCK] = lock_loss_event;
    assign event_set[`BIT_LINK] = link_fault_event;
    assign event_set[`BIT_REALIGN] = realign_event;
    assign event_set[`BIT_OSC_PHASE] = oscillator_phase_event;
    assign event_set[`BIT_DIVIDER] = divider_mismatch_event;

    // write-one-to-clear with set winning; reserved bits plain read/write
    assign next_flags[5:0] = wr_flags ? ((fault_flag_register[5:0] & ~reg_wdata[5:0])
        | event_set) : (fault_flag_register[5:0] | event_set);
    assign next_flags[7:6] = wr_flags ? reg_wdata[7:6] : fault_flag_register[7:6];

    // lane flags: own clear and whole-vector clear from the fifo flag
    assign next_lanes = ((wr_flags && reg_wdata[`BIT_FIFO]) ? 16'h0000
        : wr_lanes ? (lane_fifo_fault_flags & ~reg_wdata)
        : lane_fifo_fault_flags) | lane_set;

    // flag, suppress and summary registers
    always @(posedge clk)
    begin
        if (rst)
        begin
            fault_flag_register <= `RST_FAULT_FLAGS;
            fault_suppress_register <= `RST_FAULT_SUPPRESS;
            lane_fifo_fault_flags <= `RST_LANE_FIFO_FAULTS;
            alarm_summary <= 1'b0;
        end
        else
        begin
            fault_flag_register <= next_flags;
            lane_fifo_fault_flags <= next_lanes;
            if (host_wr && reg_addr == `ADDR_FAULT_SUPPRESS)
            begin
                fault_suppress_register <= reg_wdata[7:0];
            end
            alarm_summary <= |(fault_flag_register[5:0]
                & ~fault_suppress_register[5:0]);
        end
    end

    // fuse load sequencer state
    always @*
    begin
        next_state = state;
        case (state)
            ST_LOAD:
            begin
                if (load_slot == `SLOT_B_SINGLE)
                begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: next_state = ST_RUN;
            default: next_state = ST_LOAD;
        endcase
    end

    // sequencer registers; ready rises with the last fuse write
    always @(posedge clk)
    begin
        if (rst)
        begin
            state <= ST_LOAD;
            load_slot <= 2'h0;
            reg_ready <= 1'b0;
        end
        else
        begin
            state <= next_state;
            load_slot <= load_slot + 2'h1;
            reg_ready <= (next_state == ST_RUN);
        end
    end

    // pick the fuse word for the slot being loaded
    always @*
    begin
        case (load_slot)
            `SLOT_A_DUAL: fuse_word = fuse_core_a_dual;
            `SLOT_B_DUAL: fuse_word = fuse_core_b_dual;
            `SLOT_A_SINGLE: fuse_word = fuse_core_a_single_first;
            default: fuse_word = fuse_core_b_single_first;
        endcase
    end

    // memory write: fuse defaults first, then host writes
    always @*
    begin
        if (state == ST_LOAD)
        begin
            mem_wr = 1'b1;
            mem_slot = load_slot;
            mem_wdata = fuse_word;
        end
        else
        begin
            mem_wr = host_wr && addr_slot[2];
            mem_slot = addr_slot[1:0];
            mem_wdata = reg_wdata[7:0];
        end
    end

    // which register drives each core in the present mode
    always @*
    begin
        if (dual_mode)
        begin
            a_slot = `SLOT_A_DUAL;
            b_slot = `SLOT_B_DUAL;
            next_a_valid = 1'b1;
            next_b_valid = fg_cal_en;
        end
        else
        begin
            a_slot = `SLOT_A_SINGLE;
            b_slot = `SLOT_B_SINGLE;
            next_a_valid = first_analog_input && fg_cal_en;
            next_b_valid = first_analog_input && fg_cal_en;
        end
    end

    // valid flags line up with the registered memory reads
    always @(posedge clk)
    begin
        if (rst)
        begin
            core_a_delay_valid <= 1'b0;
            core_b_delay_valid <= 1'b0;
        end
        else
        begin
            core_a_delay_valid <= next_a_valid && (state == ST_RUN);
            core_b_delay_valid <= next_b_valid && (state == ST_RUN);
        end
    end

    // local read value for the first read stage
    always @*
    begin
        case (reg_addr)
            `ADDR_SUMMARY_ALARM: rd_local = {15'h0000, alarm_summary};
            `ADDR_FAULT_FLAGS: rd_local = {8'h00, fault_flag_register};
            `ADDR_FAULT_SUPPRESS: rd_local = {8'h00, fault_suppress_register};
            `ADDR_LANE_FIFO_FAULTS: rd_local = lane_fifo_fault_flags;
            default: rd_local = 16'h0000;
        endcase
    end

    // two-stage read: capture the local value and the memory word, then present
    // the one that belongs to the read; each stage keeps its own copy so that
    // back-to-back reads cannot overwrite an answer still in flight
    always @(posedge clk)
    begin
        if (rst)
        begin
            rd_pend <= 1'b0;
            rd_from_mem <= 1'b0;
            rd_hold <= 16'h0000;
            reg_rvalid <= 1'b0;
            reg_rdata <= 16'h0000;
        end
        else
        begin
            rd_pend <= reg_rd && (state == ST_RUN);
            rd_from_mem <= addr_slot[2];
            rd_hold <= rd_local;
            if (rd_pend)
            begin
                if (rd_from_mem)
                begin
                    reg_rdata <= {8'h00, mem_host_data};
                end
                else
                begin
                    reg_rdata <= rd_hold;
                end
            end
            reg_rvalid <= rd_pend;
        end
    end

    // delay words; a host write and a mode change in one cycle leave the
    // core on the old word for one cycle
    sample_delay_mem u_mem (
        .clk(clk),
        .wr_en(mem_wr),
        .wr_slot(mem_slot),
        .wr_data(mem_wdata),
        .host_slot(addr_slot[1:0]),
        .host_data(mem_host_data),
        .a_slot(a_slot),
        .a_data(core_a_delay),
        .b_slot(b_slot),
        .b_data(core_b_delay)
    );

endmodule // alarm_timing_regs

// ### verilog/sample_delay_mem.v
`timescale 1ns/1ps
`include "alarm_timing_defs.vh"

// four 8-bit timing-adjust words, one write port, three registered read ports
module sample_delay_mem (
    input wire clk,
    input wire wr_en,
    input wire [1:0] wr_slot,
    input wire [7:0] wr_data,
    input wire [1:0] host_slot,
    output reg [7:0] host_data,
    input wire [1:0] a_slot,
    output reg [7:0] a_data,
    input wire [1:0] b_slot,
    output reg [7:0] b_data
);

    reg [7:0] words [0:`DELAY_SLOTS-1];

    // write, then registered reads (old data on a same-cycle collision)
    always @(posedge clk)
    begin
        if (wr_en)
        begin
            words[wr_slot] <= wr_data;
        end
        host_data <= words[host_slot];
        a_data <= words[a_slot];
        b_data <= words[b_slot];
    end

endmodule // sample_delay_mem
